// ===== sfs_bench.sv
// Self-checking bench joining the host and device ends over the flash link.
`timescale 1ns/1ns
module sfs_bench
  import sfs_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int WR_CYC = 1200;
  localparam int ER_CYC = 300;
  logic mclk = 1'b0;
  logic rst = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  sfs_byte_t cmd_op = 8'h00;
  sfs_addr_t cmd_addr = 24'h00_0000;
  sfs_byte_t cmd_wdata = 8'h00;
  logic [15:0] cmd_rd_len = 16'h0000;
  logic wp_n_in = 1'b1;
  logic rd_valid;
  sfs_byte_t rd_data;
  logic otp_mode = 1'b0;
  logic mem_we = 1'b0;
  logic [7:0] mem_addr = 8'h00;
  sfs_byte_t mem_wdata = 8'h00;
  logic [7:0] status;
  logic quad_mode;
  int err_count = 0;
  int check_count = 0;
  sfs_byte_t rq[$];

  always #25 mclk = ~mclk;

  sfs_link_if lnk();
  sfs_host u_sfs_host (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rd_len(cmd_rd_len),
    .wp_n_in(wp_n_in), .rd_valid(rd_valid), .rd_data(rd_data), .lnk(lnk.host));
  sfs_dev #(.WR_CYC(WR_CYC), .PROG_CYC(ER_CYC), .ERASE_CYC(ER_CYC)) u_sfs_dev (.mclk(mclk),
    .rst(rst), .otp_mode(otp_mode), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .status(status), .quad_mode(quad_mode), .lnk(lnk.device));
  sfs_link_chk u_sfs_link_chk (.mclk(mclk), .rst(rst), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .io0_h_o(lnk.io0_h_o), .io0_h_oe(lnk.io0_h_oe), .io0_d_oe(lnk.io0_d_oe),
    .io1_d_o(lnk.io1_d_o), .io1_d_oe(lnk.io1_d_oe));

  // Collects every byte the host hands back.
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) begin
      rq.push_back(rd_data);
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input sfs_byte_t exp, input sfs_byte_t got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Runs one frame and waits, bounded, until the host is idle again.
  task automatic cmd(input sfs_byte_t op, input sfs_addr_t a, input sfs_byte_t d, input int n);
    int w;
    w = 0;
    rq.delete();
    @(posedge mclk);
    #2;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_rd_len = 16'(n);
    @(posedge mclk);
    #2;
    cmd_valid = 1'b0;
    do begin
      @(posedge mclk);
      #1;
      w++;
    end while (cmd_ready !== 1'b1 && w < 5000);
    chk("host ready", 8'h01, {7'h00, cmd_ready});
    chk("byte count", 8'(n), 8'(rq.size()));
  endtask : cmd

  task automatic op1(input sfs_byte_t op, input sfs_byte_t d);
    cmd(op, 24'h00_0000, d, 0);
  endtask : op1

  // A refused read leaves the lines floating high, so every byte reads all ones.
  task automatic rd(input sfs_byte_t op, input sfs_addr_t a, input int n, input logic ok);
    sfs_addr_t p;
    cmd(op, a, 8'h00, n);
    for (int i = 0; i < n; i++) begin
      p = a + 24'(i);
      chk("read data", ok ? (p[7:0] ^ 8'hA5) : 8'hFF, rq[i]);
    end
  endtask : rd

  task automatic rd_stat(input sfs_byte_t exp, input int n);
    cmd(8'h05, 24'h00_0000, 8'h00, n);
    for (int i = 0; i < n; i++) begin
      chk("status read", exp, rq[i]);
    end
  endtask : rd_stat

  task automatic wr_stat(input sfs_byte_t d);
    op1(8'h06, 8'h00);
    op1(8'h01, d);
  endtask : wr_stat

  task automatic settle;
    repeat (WR_CYC) @(posedge mclk);
    #2;
  endtask : settle

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  // Cuts a hang short well beyond the expected run of about 20000 cycles.
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    complete_run();
  end

  // Preloads the array, then works through status, protection and read frames.
  initial begin
    #2;
    rst = 1'b1; // A real rising edge, so the link-side flops see their reset too.
    repeat (5) @(posedge mclk);
    #2;
    rst = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem_we = 1'b1;
      mem_addr = 8'(i);
      mem_wdata = 8'(i) ^ 8'hA5;
      @(posedge mclk);
      #2;
    end
    mem_we = 1'b0;
    rd_stat(8'h00, 1);
    op1(8'h01, 8'hFC);
    rd_stat(8'h00, 1);
    op1(8'h06, 8'h00);
    rd_stat(8'h02, 2);
    op1(8'h01, 8'h54);
    rd_stat(8'h57, 1);
    rd(8'h03, 24'h00_0000, 1, 1'b0);
    settle();
    rd_stat(8'h54, 1);
    chk("status port", 8'h54, status);
    op1(8'h06, 8'h00);
    op1(8'hC7, 8'h00);
    rd_stat(8'h56, 1);
    rd(8'h03, 24'hFF_FFFE, 3, 1'b1);
    rd(8'h0B, 24'h00_0010, 2, 1'b1);
    rd(8'h3B, 24'h00_00FE, 4, 1'b1);
    cmd(8'h20, 24'hF0_0000, 8'h00, 0);
    rd_stat(8'h56, 1);
    cmd(8'h20, 24'h00_0000, 8'h00, 0);
    rd_stat(8'h57, 1);
    settle();
    wr_stat(8'hC0);
    settle();
    wp_n_in = 1'b0;
    wr_stat(8'h80);
    settle();
    rd_stat(8'h80, 1);
    wr_stat(8'h00);
    rd_stat(8'h82, 1);
    #1;
    wp_n_in = 1'b1;
    op1(8'h01, 8'h00);
    settle();
    rd_stat(8'h00, 1);
    #1;
    otp_mode = 1'b1;
    wr_stat(8'h3C);
    settle();
    rd_stat(8'h80, 1);
    wr_stat(8'h00);
    rd_stat(8'h82, 1);
    #1;
    otp_mode = 1'b0;
    op1(8'h01, 8'h00);
    settle();
    rd_stat(8'h00, 1);
    op1(8'h06, 8'h00);
    op1(8'hC7, 8'h00);
    rd_stat(8'h03, 1);
    settle();
    op1(8'h38, 8'h00);
    chk("quad mode", 8'h01, {7'h00, quad_mode});
    rd(8'h03, 24'h00_0000, 1, 1'b0);
    rd(8'h3B, 24'h00_0000, 2, 1'b0);
    complete_run();
  end
endmodule : sfs_bench

// ===== sfs_dev.sv
// Flash device end: status register, status write cycle and the read commands.
// How it works
// - busy flag high exactly while a cycle runs.
// - no write-type command without enable latch.
// - protect bits shield a top region from writes.
// - chip erase only with all protect bits zero.
// - protect bits frozen under hardware protection.
// - pin-disable bit, reset zero, ignores protect pin.
// - lock bit plus low pin freezes status writes.
// - one-time lock blocks writes but not chip erase, sets once only.
// - one-time mode status write just sets lock.
// - enable first, then 01h plus one byte.
// - status write never touches bits one, zero.
// - status write needs exactly sixteen clocks.
// - select rise starts timed cycle, then clears.
// - plain read: address in, data out.
// - address increments per byte, wraps to zero.
// - reads refused while a cycle is running.
// - fast read adds one dummy byte.
// - dual read drives two lines per clock.
// - dual read: eight dummy clocks, input ignored.
// - host frees data line before dual output.
// - 06h sets the write enable latch.
// - status readable anytime and repeatedly.
// - quad mode disables plain and dual reads.
`timescale 1ns/1ns
`include "sfs_map.svh"
module sfs_dev
  import sfs_pkg::*;
#(
  parameter int MEM_AW = 8,
  parameter int CNT_W = 32,
  parameter int WR_CYC = `SFS_T_W_US * 1000 / `SFS_MCLK_NS,
  parameter int PROG_CYC = `SFS_T_PROG_US * 1000 / `SFS_MCLK_NS,
  parameter int ERASE_CYC = `SFS_T_ERASE_US * 1000 / `SFS_MCLK_NS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic otp_mode,
  input wire logic mem_we,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] status,
  output logic quad_mode,
  sfs_link_if.device lnk
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic link_rst;
  logic first_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [31:0] sr_q;
  logic [31:0] sr_d;
  sfs_byte_t cmd_q;
  sfs_byte_t data_q;
  sfs_addr_t addr_q;
  logic rd_ok_q;
  logic [8:0] lsync1_q;
  logic [8:0] lsync2_q;
  sfs_byte_t stat_s;
  logic quad_s;
  sfs_byte_t mem_q [2**MEM_AW];
  logic [CNT_W-1:0] off;
  sfs_addr_t byte_addr;
  sfs_byte_t cur_byte;
  logic [1:0] pair;
  logic drive1;
  logic drive2;
  logic [2:0] cs_sync_q;
  logic [1:0] wp_sync_q;
  logic frame_end;
  logic wel_q;
  logic wip_q;
  logic quad_q;
  logic [3:0] bp_q;
  logic pdis_q;
  logic swp_q;
  logic [31:0] busy_cnt_q;
  logic hardware_protected_mode;
  logic otp_locked;
  logic len8;
  logic len16;
  logic len32;
  logic start_wr;
  logic start_pg;
  logic start_er;

  // True when the address falls in the top region selected by the protect bits.
  function automatic logic sfs_prot(input logic [3:0] bp, input sfs_addr_t a);
    logic hit;
    hit = (bp != 4'h0);
    for (int i = 16; i < 24; i++) begin
      if (i >= 15 + int'(bp)) begin
        hit = hit & a[i];
      end
    end
    return hit;
  endfunction : sfs_prot

  // ------------------------------------------------------------
  // Link clock domain: shifting in
  // ------------------------------------------------------------
  // Chip select high ends the frame; it resets only the per-frame logic so that
  // the frame length and bytes stay put for the main clock to judge.
  assign link_rst = rst | lnk.cs_n;

  // Marks that no rising edge has yet been seen in this frame.
  always_ff @(posedge lnk.sclk or posedge link_rst) begin
    if (link_rst) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  assign cnt_d = first_q ? CNT_W'(1) : cnt_q + CNT_W'(1);
  assign sr_d = {sr_q[30:0], lnk.io0};

  // Bit counter and shift register; input during dummy clocks lands here unused.
  always_ff @(posedge lnk.sclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      sr_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      sr_q <= sr_d;
    end
  end

  // Capture opcode, data byte and address at their last bit.
  always_ff @(posedge lnk.sclk or posedge rst) begin
    if (rst) begin
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      addr_q <= 24'h00_0000;
      rd_ok_q <= 1'b0;
    end else begin
      if (cnt_d == CNT_W'(`SFS_CMD_END)) begin
        cmd_q <= sr_d[7:0];
        rd_ok_q <= !stat_s[`SFS_ST_BUSY_BIT] &&
          !(quad_s && (sr_d[7:0] == `SFS_OP_READ || sr_d[7:0] == `SFS_OP_DUAL_RD));
      end
      if (cnt_d == CNT_W'(`SFS_STAT_WR_END)) begin
        data_q <= sr_d[7:0];
      end
      if (cnt_d == CNT_W'(`SFS_ADDR_END)) begin
        addr_q <= sr_d[23:0];
      end
    end
  end

  // Status and mode cross in per bit; they change together only as a cycle starts or ends,
  // where a one-clock mix of old and new is harmless to a polling host.
  always_ff @(posedge lnk.sclk or posedge rst) begin
    if (rst) begin
      lsync1_q <= '0;
      lsync2_q <= '0;
    end else begin
      lsync1_q <= {quad_q, status};
      lsync2_q <= lsync1_q;
    end
  end
  assign stat_s = lsync2_q[7:0];
  assign quad_s = lsync2_q[8];

  // ------------------------------------------------------------
  // Link clock domain: shifting out
  // ------------------------------------------------------------
  // Select the byte and bit to drive from the bit count past the header.
  always_comb begin
    off = '0;
    drive1 = 1'b0;
    drive2 = 1'b0;
    if (!first_q && cnt_q >= CNT_W'(`SFS_CMD_END)) begin
      case (cmd_q)
        `SFS_OP_STAT_RD: begin
          off = cnt_q - CNT_W'(`SFS_CMD_END);
          drive1 = 1'b1;
        end
        `SFS_OP_READ: begin
          off = cnt_q - CNT_W'(`SFS_ADDR_END);
          drive1 = rd_ok_q && cnt_q >= CNT_W'(`SFS_ADDR_END);
        end
        `SFS_OP_FAST_RD: begin
          off = cnt_q - CNT_W'(`SFS_FAST_END);
          drive1 = rd_ok_q && cnt_q >= CNT_W'(`SFS_FAST_END);
        end
        `SFS_OP_DUAL_RD: begin
          off = cnt_q - CNT_W'(`SFS_FAST_END);
          drive2 = rd_ok_q && cnt_q >= CNT_W'(`SFS_FAST_END);
        end
        default: begin
          off = '0;
        end
      endcase
    end
    byte_addr = addr_q + (drive2 ? 24'(off >> 2) : 24'(off >> 3));
    pair = 2'd3 - off[1:0];
    cur_byte = (cmd_q == `SFS_OP_STAT_RD) ? stat_s : mem_q[byte_addr[MEM_AW-1:0]];
  end

  // Output lines change on falling edges and float whenever deselected.
  always_ff @(negedge lnk.sclk or posedge link_rst) begin
    if (link_rst) begin
      lnk.io0_d_o <= 1'b0;
      lnk.io0_d_oe <= 1'b0;
      lnk.io1_d_o <= 1'b0;
      lnk.io1_d_oe <= 1'b0;
    end else begin
      lnk.io1_d_oe <= drive1 | drive2;
      lnk.io0_d_oe <= drive2;
      lnk.io1_d_o <= drive2 ? cur_byte[{pair, 1'b1}] : cur_byte[3'd7 - off[2:0]];
      lnk.io0_d_o <= cur_byte[{pair, 1'b0}];
    end
  end

  // Array contents come from the main clock side; write it only while no read runs.
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem_q[mem_addr] <= mem_wdata;
    end
  end

  // ------------------------------------------------------------
  // Main clock domain: command execution
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_sync_q <= 3'b111;
      wp_sync_q <= 2'b11;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], lnk.cs_n};
      wp_sync_q <= {wp_sync_q[0], lnk.wp_n};
    end
  end
  assign frame_end = cs_sync_q[1] & ~cs_sync_q[2];

  assign hardware_protected_mode = swp_q & ~pdis_q & ~wp_sync_q[1] & ~otp_mode;
  assign otp_locked = otp_mode & swp_q;
  assign len8 = (cnt_q == CNT_W'(`SFS_CMD_END));
  assign len16 = (cnt_q == CNT_W'(`SFS_STAT_WR_END));
  assign len32 = (cnt_q == CNT_W'(`SFS_ADDR_END));

  // Frame length and bytes are stable here: the link clock stands while deselected.
  always_comb begin
    start_wr = 1'b0;
    start_pg = 1'b0;
    start_er = 1'b0;
    if (frame_end && wel_q && !wip_q) begin
      case (cmd_q)
        `SFS_OP_STAT_WR: start_wr = len16 && !hardware_protected_mode && !otp_locked;
        `SFS_OP_PAGE_PROG: start_pg = cnt_q >= CNT_W'(`SFS_FAST_END) && cnt_q[2:0] == 3'd0 &&
          !sfs_prot(bp_q, addr_q) && !otp_locked;
        `SFS_OP_SECT_ERASE,
        `SFS_OP_BLK_ERASE: start_er = len32 && !sfs_prot(bp_q, addr_q) && !otp_locked;
        `SFS_OP_CHIP_ERASE,
        `SFS_OP_CHIP_ERASE_ALT: start_er = len8 && bp_q == 4'h0;
        default: start_er = 1'b0;
      endcase
    end
  end

  // Self-timed cycle; the flag tracks the counter so it reads busy exactly throughout.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 32'h0000_0000;
      wip_q <= 1'b0;
    end else if (start_wr | start_pg | start_er) begin
      busy_cnt_q <= start_wr ? 32'(WR_CYC) : (start_pg ? 32'(PROG_CYC) : 32'(ERASE_CYC));
      wip_q <= 1'b1;
    end else if (busy_cnt_q == 32'h0000_0001) begin
      busy_cnt_q <= 32'h0000_0000;
      wip_q <= 1'b0;
    end else if (busy_cnt_q != 32'h0000_0000) begin
      busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
    end
  end

  // Enable latch: set by the enable opcode, cleared by disable or a finished cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wel_q <= 1'b0;
    end else if (wip_q && busy_cnt_q == 32'h0000_0001) begin
      wel_q <= 1'b0;
    end else if (frame_end && len8 && !wip_q && cmd_q == `SFS_OP_WR_EN) begin
      wel_q <= 1'b1;
    end else if (frame_end && len8 && !wip_q && cmd_q == `SFS_OP_WR_DIS) begin
      wel_q <= 1'b0;
    end
  end

  // Non-volatile bits take their new value as the cycle starts; bits one and zero
  // of the data byte are never looked at.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {swp_q, pdis_q, bp_q} <= `SFS_NV_RESET;
    end else if (start_wr && otp_mode) begin
      swp_q <= 1'b1;
    end else if (start_wr) begin
      {swp_q, pdis_q, bp_q} <= data_q[7:2];
    end
  end

  // Quad command mode stays on until reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      quad_q <= 1'b0;
    end else if (frame_end && len8 && cmd_q == `SFS_OP_QUAD_MODE) begin
      quad_q <= 1'b1;
    end
  end

  assign status = {swp_q, pdis_q, bp_q, wel_q, wip_q};
  assign quad_mode = quad_q;

endmodule : sfs_dev

// ===== sfs_host.sv
// Host controller end: makes the link clock and runs one command per request.
`timescale 1ns/1ns
`include "sfs_map.svh"
module sfs_host
  import sfs_pkg::*;
#(
  parameter int HALF_DIV = `SFS_HALF_DIV,
  parameter int GAP_CYC = `SFS_GAP_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sfs_byte_t cmd_op,
  input wire sfs_addr_t cmd_addr,
  input wire sfs_byte_t cmd_wdata,
  input wire logic [15:0] cmd_rd_len,
  input wire logic wp_n_in,
  output logic rd_valid,
  output sfs_byte_t rd_data,
  sfs_link_if.host lnk
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  sfs_hstate_t state_q;
  logic [7:0] div_q;
  logic sclk_q;
  logic tick;
  logic [39:0] tx_q;
  logic [5:0] tx_len_q;
  logic [5:0] bit_q;
  logic dual_q;
  logic [15:0] rd_left_q;
  logic [2:0] rx_bit_q;
  sfs_byte_t rx_q;
  logic [1:0] io0_sync_q;
  logic [1:0] io1_sync_q;

  // Bits the host sends before any data comes back.
  function automatic logic [5:0] sfs_tx_len(input sfs_byte_t op);
    case (op)
      `SFS_OP_STAT_WR: return 6'd16;
      `SFS_OP_READ, `SFS_OP_SECT_ERASE, `SFS_OP_BLK_ERASE: return 6'd32;
      `SFS_OP_FAST_RD, `SFS_OP_DUAL_RD, `SFS_OP_PAGE_PROG: return 6'd40;
      default: return 6'd8;
    endcase
  endfunction : sfs_tx_len

  assign cmd_ready = (state_q == SFS_H_IDLE);
  assign tick = (div_q == 8'(HALF_DIV - 1));
  assign lnk.sclk = sclk_q;
  assign lnk.wp_n = wp_n_in;

  // Returning lines pass two flops before being read.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      io0_sync_q <= 2'b11;
      io1_sync_q <= 2'b11;
    end else begin
      io0_sync_q <= {io0_sync_q[0], lnk.io0};
      io1_sync_q <= {io1_sync_q[0], lnk.io1};
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Mode 0 clock: idles low, device samples on rise, host shifts on fall.
  // Input is sampled at the fall, two flops late, so the divider must stay at
  // two or more half-period cycles.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= SFS_H_IDLE;
      div_q <= 8'h00;
      sclk_q <= 1'b0;
      lnk.cs_n <= 1'b1;
      lnk.io0_h_o <= 1'b0;
      lnk.io0_h_oe <= 1'b0;
      tx_q <= '0;
      tx_len_q <= 6'd0;
      bit_q <= 6'd0;
      dual_q <= 1'b0;
      rd_left_q <= 16'h0000;
      rx_bit_q <= 3'd0;
      rx_q <= 8'h00;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      // The gap keeps counting past the half period; a wrap there would never reach GAP_CYC.
      div_q <= ((tick && state_q != SFS_H_GAP) || state_q == SFS_H_IDLE) ? 8'h00 :
        div_q + 8'h01;
      case (state_q)
        SFS_H_IDLE: begin
          if (cmd_valid) begin
            tx_q <= (cmd_op == `SFS_OP_STAT_WR) ? {cmd_op, cmd_wdata, 24'h00_0000} :
              {cmd_op, cmd_addr, cmd_wdata};
            tx_len_q <= sfs_tx_len(cmd_op);
            dual_q <= (cmd_op == `SFS_OP_DUAL_RD);
            rd_left_q <= (cmd_op == `SFS_OP_READ || cmd_op == `SFS_OP_FAST_RD ||
              cmd_op == `SFS_OP_DUAL_RD || cmd_op == `SFS_OP_STAT_RD) ? cmd_rd_len : 16'h0000;
            bit_q <= 6'd0;
            rx_bit_q <= 3'd0;
            lnk.cs_n <= 1'b0;
            lnk.io0_h_o <= cmd_op[7];
            lnk.io0_h_oe <= 1'b1;
            state_q <= SFS_H_TX;
          end
        end
        SFS_H_TX: begin
          if (bit_q == tx_len_q && dual_q) begin
            lnk.io0_h_oe <= 1'b0;
          end
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
            bit_q <= bit_q + 6'd1;
          end else if (tick) begin
            sclk_q <= 1'b0;
            if (bit_q == tx_len_q) begin
              lnk.io0_h_oe <= !dual_q && rd_left_q != 16'h0000;
              state_q <= (rd_left_q != 16'h0000) ? SFS_H_RX : SFS_H_GAP;
              lnk.cs_n <= (rd_left_q == 16'h0000);
            end else begin
              tx_q <= {tx_q[38:0], 1'b0};
              lnk.io0_h_o <= tx_q[38];
            end
          end
        end
        SFS_H_RX: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
          end
          if (tick && sclk_q) begin
            rx_q <= dual_q ? {rx_q[5:0], io1_sync_q[1], io0_sync_q[1]} :
              {rx_q[6:0], io1_sync_q[1]};
            rx_bit_q <= rx_bit_q + (dual_q ? 3'd2 : 3'd1);
            if (rx_bit_q == (dual_q ? 3'd6 : 3'd7)) begin
              rd_valid <= 1'b1;
              rd_data <= dual_q ? {rx_q[5:0], io1_sync_q[1], io0_sync_q[1]} :
                {rx_q[6:0], io1_sync_q[1]};
              rd_left_q <= rd_left_q - 16'h0001;
              if (rd_left_q == 16'h0001) begin
                lnk.cs_n <= 1'b1;
                lnk.io0_h_oe <= 1'b0;
                state_q <= SFS_H_GAP;
              end
            end
          end
        end
        SFS_H_GAP: begin
          sclk_q <= 1'b0;
          lnk.cs_n <= 1'b1;
          lnk.io0_h_oe <= 1'b0;
          if (div_q == 8'(GAP_CYC - 1)) begin
            state_q <= SFS_H_IDLE;
          end
        end
        default: begin
          state_q <= SFS_H_IDLE;
        end
      endcase
    end
  end

endmodule : sfs_host

// ===== sfs_link_chk.sv
// Concurrent checks on the serial flash link between the host and device ends.
`timescale 1ns/1ns
module sfs_link_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic io0_h_o,
  input wire logic io0_h_oe,
  input wire logic io0_d_oe,
  input wire logic io1_d_o,
  input wire logic io1_d_oe
);
  // ----------------------------------------
  // Frame bookkeeping
  // ----------------------------------------
  logic [15:0] rise_cnt_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Counts link clock rises within one frame; deselect clears it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rise_cnt_q <= 16'h0000;
    end else if (cs_n) begin
      rise_cnt_q <= 16'h0000;
    end else if ($rose(sclk)) begin
      rise_cnt_q <= rise_cnt_q + 16'h0001;
    end
  end

  // The device judges a frame a few cycles after deselect, so the gap must last.
  sequence s_gap_high;
    cs_n [*4];
  endsequence

  sequence s_dual_on;
    $rose(io0_d_oe) ##0 io1_d_oe;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("link clock not low while deselected");
  a_dev_release: assert property (cs_n |-> !io0_d_oe && !io1_d_oe)
    else $error("device drives a line while deselected");
  a_out_on_fall: assert property (io1_d_oe && $past(io1_d_oe) && $changed(io1_d_o) |-> !sclk)
    else $error("device output changed while link clock high");
  a_host_setup: assert property (io0_h_oe && $changed(io0_h_o) |-> !sclk)
    else $error("host data changed while link clock high");
  a_no_contention: assert property (!(io0_h_oe && io0_d_oe))
    else $error("host and device both drive line zero");
  a_frame_whole: assert property ($rose(cs_n) |-> rise_cnt_q[1:0] == 2'h0 && rise_cnt_q >= 16'h0008)
    else $error("frame ended off a unit boundary");
  a_drive_start: assert property ($rose(io1_d_oe) |-> rise_cnt_q inside {16'h0008, 16'h0020, 16'h0028})
    else $error("device output began at a wrong clock count");
  a_dual_start: assert property (s_dual_on |-> rise_cnt_q == 16'h0028)
    else $error("dual output began at a wrong clock count");
  a_dual_pair: assert property (io0_d_oe |-> io1_d_oe)
    else $error("dual output drives line zero alone");
  a_gap_hold: assert property ($rose(cs_n) |-> s_gap_high)
    else $error("deselect gap too short");
endmodule : sfs_link_chk

// ===== sfs_link_if.sv
// Serial flash link between host controller and flash device.
`timescale 1ns/1ns
interface sfs_link_if;
  logic sclk;
  logic cs_n;
  logic wp_n;
  logic io0_h_o;
  logic io0_h_oe;
  logic io0_d_o;
  logic io0_d_oe;
  logic io1_d_o;
  logic io1_d_oe;
  logic io0;
  logic io1;
  // Undriven lines float high, as a weak pull-up would leave them.
  assign io0 = io0_h_oe ? io0_h_o : (io0_d_oe ? io0_d_o : 1'b1);
  assign io1 = io1_d_oe ? io1_d_o : 1'b1;
  modport host (output sclk, cs_n, wp_n, io0_h_o, io0_h_oe, input io0, io1);
  modport device (input sclk, cs_n, wp_n, io0, io1, output io0_d_o, io0_d_oe, io1_d_o, io1_d_oe);
endinterface : sfs_link_if

// ===== sfs_map.svh
// Opcodes, status bit positions, reset values and timing counts of the flash link.
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH
`define SFS_OP_STAT_WR 8'h01
`define SFS_OP_PAGE_PROG 8'h02
`define SFS_OP_READ 8'h03
`define SFS_OP_WR_DIS 8'h04
`define SFS_OP_STAT_RD 8'h05
`define SFS_OP_WR_EN 8'h06
`define SFS_OP_FAST_RD 8'h0B
`define SFS_OP_SECT_ERASE 8'h20
`define SFS_OP_QUAD_MODE 8'h38
`define SFS_OP_DUAL_RD 8'h3B
`define SFS_OP_CHIP_ERASE_ALT 8'h60
`define SFS_OP_CHIP_ERASE 8'hC7
`define SFS_OP_BLK_ERASE 8'hD8
`define SFS_ST_BUSY_BIT 0
`define SFS_ST_WEN_BIT 1
`define SFS_ST_BP_LSB 2
`define SFS_ST_PDIS_BIT 6
`define SFS_ST_SWP_BIT 7
`define SFS_NV_RESET 6'h00
`define SFS_CMD_END 8
`define SFS_STAT_WR_END 16
`define SFS_ADDR_END 32
`define SFS_FAST_END 40
`define SFS_MCLK_NS 50
`define SFS_T_W_US 10000
`define SFS_T_PROG_US 1000
`define SFS_T_ERASE_US 10000
`define SFS_HALF_DIV 4
`define SFS_GAP_CYC 8
`endif

// ===== sfs_pkg.sv
// Types shared by both ends of the flash link.
package sfs_pkg;
  typedef logic [7:0] sfs_byte_t;
  typedef logic [23:0] sfs_addr_t;
  typedef enum logic [3:0] {
    SFS_H_IDLE = 4'b0001,
    SFS_H_TX = 4'b0010,
    SFS_H_RX = 4'b0100,
    SFS_H_GAP = 4'b1000
  } sfs_hstate_t;
endpackage : sfs_pkg
